// ==== design/adc_readout_defs.svh ====
// word widths, leading zeros, reset values and counts of the serial readout
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define RESULT_BITS   14
`define WORD_BITS     16
`define FRAME_BITS    32
`define LEAD_ZEROS    2'h0

// ----------------------------------------------------------------
// falling edge counts within a frame
// ----------------------------------------------------------------
`define COUNT_W       6
`define TRACK_FALLS   6'h0F
`define SECOND_FALLS  6'h10
`define END_FALLS     6'h20

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CS_IDLE       1'b1
`define SCLK_IDLE     1'b0
`define OE_N_IDLE     1'b1
`define DATA_IDLE     1'b0

`endif

// ==== design/adc_readout_pkg.sv ====
// types shared by the serial readout modules
`include "adc_readout_defs.svh"

package adc_readout_pkg;

    typedef logic [`RESULT_BITS-1:0] result_t;
    typedef logic [`FRAME_BITS-1:0]  frame_t;
    typedef logic [`COUNT_W-1:0]     count_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CONVERT,
        PH_SECOND,
        PH_DONE
    } phase_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic ck_s1;
        logic ck_s2;
        logic ck_prev;
    } sync_state_t;

    typedef struct packed {
        phase_t  phase;
        count_t  falls;
        logic    hold;
        result_t sample_a;
        result_t sample_b;
        frame_t  sh_a;
        frame_t  sh_b;
        logic    out_a;
        logic    out_b;
        logic    oe_n_a;
        logic    oe_n_b;
        logic    busy;
    } readout_state_t;

endpackage

// ==== design/link_if.sv ====
// synchronised chip select and serial clock events
`timescale 1ns/100ps

interface link_if;
    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;

    modport source (
        output cs_low,
        output cs_fall,
        output cs_rise,
        output sclk_fall,
        output sclk_rise
    );

    modport sink (
        input  cs_low,
        input  cs_fall,
        input  cs_rise,
        input  sclk_fall,
        input  sclk_rise
    );
endinterface

// ==== design/edge_sync.sv ====
// two-flop synchronisers and edge detection for chip select and serial clock
`timescale 1ns/100ps
`include "adc_readout_defs.svh"

module edge_sync (
    input  wire logic clock_in,
    input  wire logic reset_in,
    input  wire logic chip_select_n_in,
    input  wire logic serial_clock_in,
    link_if.source    link
);
    import adc_readout_pkg::*;

    sync_state_t q;
    sync_state_t d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d         = q;
        d.cs_s1   = chip_select_n_in;
        d.cs_s2   = q.cs_s1;
        d.cs_prev = q.cs_s2;
        d.ck_s1   = serial_clock_in;
        d.ck_s2   = q.ck_s1;
        d.ck_prev = q.ck_s2;
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            q.cs_s1   <= `CS_IDLE;
            q.cs_s2   <= `CS_IDLE;
            q.cs_prev <= `CS_IDLE;
            q.ck_s1   <= `SCLK_IDLE;
            q.ck_s2   <= `SCLK_IDLE;
            q.ck_prev <= `SCLK_IDLE;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // events, read only from second and later stages
    // ----------------------------------------------------------------
    assign link.cs_low    = ~q.cs_s2;
    assign link.cs_fall   = ~q.cs_s2 & q.cs_prev;
    assign link.cs_rise   = q.cs_s2 & ~q.cs_prev;
    assign link.sclk_fall = ~q.ck_s2 & q.ck_prev;
    assign link.sclk_rise = q.ck_s2 & ~q.ck_prev;

endmodule

// ==== design/dual_adc_serial_readout.sv ====
// serial conversion and readout of a dual simultaneous-sampling converter
`timescale 1ns/100ps
`include "adc_readout_defs.svh"

module dual_adc_serial_readout (
    input  wire logic                     clock_in,
    input  wire logic                     reset_in,
    input  wire logic                     chip_select_n_in,
    input  wire logic                     serial_clock_in,
    input  wire adc_readout_pkg::result_t first_result_in,
    input  wire adc_readout_pkg::result_t second_result_in,
    output logic                          first_serial_output_out,
    output logic                          first_serial_output_oe_n_out,
    output logic                          second_serial_output_out,
    output logic                          second_serial_output_oe_n_out,
    output logic                          track_hold_out,
    output logic                          converting_out
);
    import adc_readout_pkg::*;

    readout_state_t q;
    readout_state_t d;
    logic           active;

    link_if link ();

    // ----------------------------------------------------------------
    // pin synchronisers and edge events
    // ----------------------------------------------------------------
    edge_sync u_sync (
        .clock_in         (clock_in),
        .reset_in         (reset_in),
        .chip_select_n_in (chip_select_n_in),
        .serial_clock_in  (serial_clock_in),
        .link             (link)
    );

    assign active = (q.phase == PH_CONVERT) || (q.phase == PH_SECOND);

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        if (link.cs_rise) begin
            // abort whatever is in flight and release the lines
            d.phase  = PH_IDLE;
            d.hold   = 1'b0;
            d.oe_n_a = `OE_N_IDLE;
            d.oe_n_b = `OE_N_IDLE;
            d.out_a  = `DATA_IDLE;
            d.out_b  = `DATA_IDLE;
        end else if (link.cs_fall) begin
            d.phase    = PH_CONVERT;
            d.hold     = 1'b1;
            d.falls    = '0;
            d.sample_a = first_result_in;
            d.sample_b = second_result_in;
            // each line: own word first, then the other one
            d.sh_a = {`LEAD_ZEROS, first_result_in,
                      `LEAD_ZEROS, second_result_in};
            d.sh_b = {`LEAD_ZEROS, second_result_in,
                      `LEAD_ZEROS, first_result_in};
            d.out_a  = 1'b0;
            d.out_b  = 1'b0;
            d.oe_n_a = 1'b0;
            d.oe_n_b = 1'b0;
        end else if (active) begin
            if (link.sclk_rise && q.falls >= `TRACK_FALLS) begin
                d.hold = 1'b0;
            end
            if (link.sclk_fall) begin
                d.falls = count_t'(q.falls + 6'h01);
                d.sh_a  = {q.sh_a[`FRAME_BITS-2:0], 1'b0};
                d.sh_b  = {q.sh_b[`FRAME_BITS-2:0], 1'b0};
                d.out_a = q.sh_a[`FRAME_BITS-2];
                d.out_b = q.sh_b[`FRAME_BITS-2];
                if (d.falls == `SECOND_FALLS) begin
                    d.phase = PH_SECOND;
                end
                if (d.falls == `END_FALLS) begin
                    d.phase  = PH_DONE;
                    d.oe_n_a = `OE_N_IDLE;
                    d.oe_n_b = `OE_N_IDLE;
                    d.out_a  = `DATA_IDLE;
                    d.out_b  = `DATA_IDLE;
                end
            end
        end
        // registered copy of the running phases for the status pin
        d.busy = (d.phase == PH_CONVERT) || (d.phase == PH_SECOND);
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            q.phase    <= PH_IDLE;
            q.falls    <= '0;
            q.hold     <= 1'b0;
            q.sample_a <= '0;
            q.sample_b <= '0;
            q.sh_a     <= '0;
            q.sh_b     <= '0;
            q.out_a    <= `DATA_IDLE;
            q.out_b    <= `DATA_IDLE;
            q.oe_n_a   <= `OE_N_IDLE;
            q.oe_n_b   <= `OE_N_IDLE;
            q.busy     <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign first_serial_output_out       = q.out_a;
    assign first_serial_output_oe_n_out  = q.oe_n_a;
    assign second_serial_output_out      = q.out_b;
    assign second_serial_output_oe_n_out = q.oe_n_b;
    assign track_hold_out                = q.hold;
    assign converting_out                = q.busy;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking

    default disable iff (reset_in);

    // a counted falling edge with the frame still running
    sequence s_fall_at(int n);
        active && link.sclk_fall && !link.cs_rise && (q.falls == n);
    endsequence

    sequence s_frame_start;
        link.cs_fall && !link.cs_rise;
    endsequence

    sequence s_driving_zero;
        q.hold && !q.oe_n_a && !q.oe_n_b && !q.out_a && !q.out_b;
    endsequence

    property p_start_hold;
        s_frame_start |=> s_driving_zero;
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("frame start did not hold and drive the lines");

    property p_first_zero;
        s_frame_start ##1 (!link.sclk_fall && !link.cs_rise)
            |=> !q.out_a && !q.out_b && !q.oe_n_a;
    endproperty
    a_first_zero: assert property (p_first_zero)
        else $error("leading zero not shown before first clock edge");

    property p_abort;
        link.cs_rise |=> q.oe_n_a && q.oe_n_b && !q.hold
                         && (q.phase == PH_IDLE);
    endproperty
    a_abort: assert property (p_abort)
        else $error("chip select rise did not release the lines");

    property p_hold_kept;
        active && q.hold && (q.falls < `TRACK_FALLS)
            && !link.cs_rise |=> q.hold;
    endproperty
    a_hold_kept: assert property (p_hold_kept)
        else $error("track resumed before fifteen falling edges");

    property p_track_return;
        active && q.hold && link.sclk_rise && !link.cs_rise
            && (q.falls == `TRACK_FALLS) |=> !q.hold;
    endproperty
    a_track_return: assert property (p_track_return)
        else $error("track not resumed after fifteenth falling edge");

    property p_count_on_fall;
        active && link.sclk_fall && !link.cs_rise
            |=> q.falls == $past(q.falls) + 6'h01;
    endproperty
    a_count_on_fall: assert property (p_count_on_fall)
        else $error("falling edge not counted");

    property p_second_zero;
        s_fall_at(0) |=> !q.out_a && !q.out_b;
    endproperty
    a_second_zero: assert property (p_second_zero)
        else $error("second leading zero missing");

    property p_msb_first;
        s_fall_at(1) |=> (q.out_a == q.sample_a[`RESULT_BITS-1])
                         && (q.out_b == q.sample_b[`RESULT_BITS-1]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("most significant bit not first after zeros");

    property p_lsb_held;
        s_fall_at(14) |=> ((q.out_a == q.sample_a[0])
                          && (q.out_b == q.sample_b[0])
                          && !q.oe_n_a) [*4];
    endproperty
    a_lsb_held: assert property (p_lsb_held)
        else $error("lsb not shifted at fifteenth falling edge");

    property p_second_word_a;
        s_fall_at(17) |=> q.out_a == q.sample_b[`RESULT_BITS-1];
    endproperty
    a_second_word_a: assert property (p_second_word_a)
        else $error("second converter word missing on first line");

    property p_second_word_b;
        s_fall_at(17) |=> q.out_b == q.sample_a[`RESULT_BITS-1];
    endproperty
    a_second_word_b: assert property (p_second_word_b)
        else $error("first converter word missing on second line");

    property p_end_float;
        s_fall_at(31) |=> q.oe_n_a && q.oe_n_b && (q.phase == PH_DONE);
    endproperty
    a_end_float: assert property (p_end_float)
        else $error("lines not floated at 32nd falling edge");

    property p_done_quiet;
        (q.phase == PH_DONE) && !link.cs_rise |=> q.oe_n_a && q.oe_n_b;
    endproperty
    a_done_quiet: assert property (p_done_quiet)
        else $error("line driven after dual read completed");

    property p_sample_taken;
        s_frame_start |=> (q.sample_a == $past(first_result_in))
                          && (q.sample_b == $past(second_result_in));
    endproperty
    a_sample_taken: assert property (p_sample_taken)
        else $error("results not captured at chip select fall");

    property p_drive_while_active;
        active |-> !q.oe_n_a && !q.oe_n_b;
    endproperty
    a_drive_while_active: assert property (p_drive_while_active)
        else $error("line floated while frame running");

    property p_idle_floated;
        (q.phase == PH_IDLE) |-> q.oe_n_a && q.oe_n_b
                                 && !q.out_a && !q.out_b;
    endproperty
    a_idle_floated: assert property (p_idle_floated)
        else $error("line driven with no frame selected");

    property p_no_shift_between;
        active && !link.sclk_fall && !link.cs_rise
            |=> $stable(q.out_a) && $stable(q.out_b);
    endproperty
    a_no_shift_between: assert property (p_no_shift_between)
        else $error("data changed without a serial clock fall");

    property p_count_only_on_fall;
        !link.sclk_fall && !link.cs_fall |=> $stable(q.falls);
    endproperty
    a_count_only_on_fall: assert property (p_count_only_on_fall)
        else $error("fall count moved without a serial clock fall");

    property p_hold_until_rise;
        q.hold && !link.sclk_rise && !link.cs_rise |=> q.hold;
    endproperty
    a_hold_until_rise: assert property (p_hold_until_rise)
        else $error("track resumed without a serial clock rise");

    property p_gap_zeros;
        s_fall_at(15) |=> !q.out_a && !q.out_b;
    endproperty
    a_gap_zeros: assert property (p_gap_zeros)
        else $error("leading zero of second word missing");

    property p_second_lsb_a;
        s_fall_at(30) |=> q.out_a == q.sample_b[0];
    endproperty
    a_second_lsb_a: assert property (p_second_lsb_a)
        else $error("second converter lsb missing on first line");

    property p_second_lsb_b;
        s_fall_at(30) |=> q.out_b == q.sample_a[0];
    endproperty
    a_second_lsb_b: assert property (p_second_lsb_b)
        else $error("first converter lsb missing on second line");

    property p_end_idle;
        s_fall_at(31) |=> !active && !q.out_a && !q.out_b;
    endproperty
    a_end_idle: assert property (p_end_idle)
        else $error("frame still running after 32nd falling edge");

endmodule

// ==== tb/serial_master_model.sv ====
// serial port master model: drives chip select and serial clock
`timescale 1ns/100ps

module serial_master_model (
    input  wire logic clock_in,
    input  wire logic first_line_in,
    input  wire logic second_line_in,
    input  wire logic track_hold_in,
    output logic      chip_select_n_out,
    output logic      serial_clock_out
);
    // ----------------------------------------------------------------
    // captured bits, newest in bit 0
    // ----------------------------------------------------------------
    logic [31:0] fall_a = '0;
    logic [31:0] fall_b = '0;
    logic [31:0] rise_a = '0;
    logic [31:0] rise_b = '0;
    logic [31:0] hold_f = '0;

    // serial clock stands high outside frames
    initial begin
        chip_select_n_out = 1'b1;
        serial_clock_out  = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // n serial clocks of 80 ns, falling half first
    task automatic clocks(input int n);
        for (int k = 1; k <= n; k++) begin
            @(posedge clock_in);
            serial_clock_out <= 1'b0;
            fall_a <= {fall_a[30:0], first_line_in};
            fall_b <= {fall_b[30:0], second_line_in};
            hold_f <= {hold_f[30:0], track_hold_in};
            wait_clk(5);
            serial_clock_out <= 1'b1;
            if (k <= 15) begin
                rise_a <= {rise_a[30:0], first_line_in};
                rise_b <= {rise_b[30:0], second_line_in};
            end
            wait_clk(4);
        end
    endtask

    task automatic frame(input int n, input bit keep_low);
        @(posedge clock_in);
        chip_select_n_out <= 1'b0;
        wait_clk(10);
        clocks(n);
        wait_clk(5);
        if (!keep_low) begin
            chip_select_n_out <= 1'b1;
        end
    endtask

    task automatic end_frame();
        @(posedge clock_in);
        chip_select_n_out <= 1'b1;
    endtask
endmodule

// ==== tb/dual_adc_serial_readout_tb.sv ====
// self-checking bench of the dual converter serial readout
`timescale 1ns/100ps

module dual_adc_serial_readout_tb;
    import adc_readout_pkg::*;

    logic    clock_in;
    logic    reset_in;
    result_t first_q;
    result_t second_q;
    logic    cs_n;
    logic    sclk;
    logic    a_out;
    logic    a_oe_n;
    logic    b_out;
    logic    b_oe_n;
    logic    hold;
    logic    conv;
    logic    float_q;
    wire     line_a;
    wire     line_b;
    int      error_cnt;
    int      comparisons;

    // ----------------------------------------------------------------
    // clock, floating lines and instances
    // ----------------------------------------------------------------
    always #4 clock_in = ~clock_in;
    always @(posedge clock_in) float_q <= ~float_q;
    // a released line shows a changing pattern, not its last value
    assign line_a = a_oe_n ? float_q : a_out;
    assign line_b = b_oe_n ? float_q : b_out;

    dual_adc_serial_readout uut (
        .clock_in                      (clock_in),
        .reset_in                      (reset_in),
        .chip_select_n_in              (cs_n),
        .serial_clock_in               (sclk),
        .first_result_in               (first_q),
        .second_result_in              (second_q),
        .first_serial_output_out       (a_out),
        .first_serial_output_oe_n_out  (a_oe_n),
        .second_serial_output_out      (b_out),
        .second_serial_output_oe_n_out (b_oe_n),
        .track_hold_out                (hold),
        .converting_out                (conv)
    );

    serial_master_model master (
        .clock_in          (clock_in),
        .first_line_in     (line_a),
        .second_line_in    (line_b),
        .track_hold_in     (hold),
        .chip_select_n_out (cs_n),
        .serial_clock_out  (sclk)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    task automatic check_idle();
        check("first oe_n idle", 1'b1, a_oe_n);
        check("second oe_n idle", 1'b1, b_oe_n);
        check("converting idle", 1'b0, conv);
        check("track idle", 1'b0, hold);
    endtask

    task automatic check_words(input result_t a, input result_t b);
        check("first line word", {2'b00, a}, master.fall_a[15:0]);
        check("second line word", {2'b00, b}, master.fall_b[15:0]);
        check("first rise bits", {1'b0, a}, master.rise_a[14:0]);
        check("second rise bits", {1'b0, b}, master.rise_b[14:0]);
        check("hold per fall", 16'hFFFE, master.hold_f[15:0]);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic short_read();
        first_q  <= 14'h2A5B;
        second_q <= 14'h15A4;
        fork
            master.frame(16, 1'b0);
            begin
                wait_clk(6);
                check("first oe_n at select", 1'b0, a_oe_n);
                check("second oe_n at select", 1'b0, b_oe_n);
                check("first lead zero", 1'b0, a_out);
                check("second lead zero", 1'b0, b_out);
                check("hold at select", 1'b1, hold);
                check("converting", 1'b1, conv);
                first_q  <= 14'h0000;
                second_q <= 14'h3FFF;
            end
        join
        wait_clk(6);
        check_words(14'h2A5B, 14'h15A4);
        check_idle();
    endtask

    task automatic abort_restart();
        master.frame(8, 1'b0);
        wait_clk(6);
        check_idle();
        first_q  <= 14'h3FFF;
        second_q <= 14'h0001;
        master.frame(16, 1'b0);
        wait_clk(6);
        check_words(14'h3FFF, 14'h0001);
    endtask

    task automatic dual_read();
        first_q  <= 14'h1C3E;
        second_q <= 14'h0F81;
        master.frame(32, 1'b1);
        check("first line dual", {16'h1C3E, 16'h0F81}, master.fall_a);
        check("second line dual", {16'h0F81, 16'h1C3E}, master.fall_b);
        check_idle();
        master.clocks(3);
        check("first oe_n after end", 1'b1, a_oe_n);
        check("second oe_n after end", 1'b1, b_oe_n);
        master.end_frame();
        wait_clk(6);
        check_idle();
    endtask

    // chip select rises in the middle of the second word
    task automatic cut_dual_read();
        first_q  <= 14'h1C3E;
        second_q <= 14'h0F81;
        master.frame(24, 1'b0);
        wait_clk(6);
        check("first line cut", 8'h0F, master.fall_a[7:0]);
        check("second line cut", 8'h1C, master.fall_b[7:0]);
        check_idle();
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        clock_in    = 1'b0;
        reset_in    = 1'b1;
        first_q     = '0;
        second_q    = '0;
        float_q     = 1'b0;
        error_cnt   = 0;
        comparisons = 0;
        wait_clk(10);
        reset_in <= 1'b0;
        wait_clk(2);
        check_idle();
        short_read();
        abort_restart();
        dual_read();
        cut_dual_read();
        wrap_up();
    end
endmodule
